// ### rtl/fcl_pkg.sv
package fcl_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THRESH = 8'h04;
  localparam logic [7:0] OFS_MON = 8'h08;
  localparam logic [7:0] OFS_LIM = 8'h0C;
  localparam logic [7:0] OFS_PWM = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_REQ = 8'h18;

  localparam logic [31:0] CTRL_RST = 32'h0000_0300;
  localparam logic [31:0] THRESH_RST = 32'h0546_280A;
  localparam logic [31:0] MON_RST = 32'h001E_0078;
  localparam logic [31:0] LIM_RST = 32'h0000_0000;
  localparam logic [31:0] PWM_RST = 32'h000B_000A;

  // ==========================================================
  // Field positions
  localparam int F_AUTO = 0;
  localparam int F_LIMEN = 1;
  localparam int F_MONEN = 2;
  localparam int F_MODE = 3;
  localparam int F_RECOV = 6;
  localparam int F_HPOL = 8;
  localparam int F_SEND = 9;
  localparam int F_THR1 = 0;
  localparam int F_THR2 = 8;
  localparam int F_THR3 = 16;
  localparam int F_HYST = 24;
  localparam int F_MONT = 0;
  localparam int F_FALLB = 16;
  localparam int LIM_STRIDE = 8;
  localparam int F_LMODE = 0;
  localparam int F_LLO = 2;
  localparam int F_LHI = 4;
  localparam int F_PCYC = 0;
  localparam int F_SSPD = 16;
  localparam int F_SDWELL = 18;
  localparam int F_ST_SPD = 0;
  localparam int F_ST_FAULT = 2;
  localparam int F_ST_HEAT = 3;
  localparam int F_ST_AUTO = 4;
  localparam int F_ST_LIM = 5;
  localparam int F_ST_HV = 16;
  localparam int F_ST_CV = 24;
  localparam int F_REQ_SEND = 0;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 10;
  localparam int CYC_PER_TICK = CLK_HZ / 1000 * TICK_MS;
  localparam logic [6:0] TICKS_PER_S = 7'(1000 / TICK_MS);
  localparam logic [15:0] MON_MIN_S = 16'h001E;

  // ==========================================================
  // Enumerations
  typedef enum logic [2:0] {
    HV_1CV_2P = 3'h0, HV_1CV_4P_SW = 3'h1, HV_2CV_2P = 3'h2,
    HV_2CV_2P_SW = 3'h3, HV_2CV_4P = 3'h4
  } fcl_hvac_t;
  typedef enum logic [1:0] {
    LIM_INACT = 2'h0, LIM_HOLD = 2'h1, LIM_OFF = 2'h2, LIM_ON = 2'h3
  } fcl_lim_t;
  typedef enum logic [1:0] {
    SND_UPDATE = 2'h0, SND_CHANGE = 2'h1, SND_REQ = 2'h2, SND_BOTH = 2'h3
  } fcl_send_t;
  typedef enum logic [1:0] {
    RCV_KEEP = 2'h0, RCV_HEAT = 2'h1, RCV_COOL = 2'h2
  } fcl_recov_t;
  typedef enum logic [2:0] {
    FS_OFF = 3'b001, FS_START = 3'b010, FS_RUN = 3'b100
  } fcl_fan_t;

endpackage

// ### rtl/fcl_top.sv
`timescale 1ns/1ps
// How it works
// - Fan turns on when control value reaches switch-on threshold, off below it.
// - One hysteresis, 0 to 31 percent, applies to all three speed thresholds.
// - Zero hysteresis switches speed exactly at each threshold crossing.
// - Upper point is threshold plus hysteresis, lower point threshold minus it.
// - Four one-bit limitation inputs, each restricting fan speed when enabled.
// - Start-up speed runs first from OFF, before limitation takes effect.
// - Limitation one has highest priority, four the lowest.
// - Emergency value is still bounded by an active limitation.
// - Manual action ends automatic mode; limitations stay in force.
// - Telegram 1 activates a limitation, telegram 0 releases it.
// - Active limitation sets its speed; out-of-range requests clamp to range edge.
// - Valves hold during limitation; recomputed and applied when it ends.
// - Per-limitation choice: inactive, unchanged, off or on within a range.
// - Selectable pipe-system mode; only the two single-value modes differ, the others drive heating from one value, cooling closed.
// - A valve deactivated by the mode is driven fully closed.
// - No control value within monitoring time raises fault and emergency mode.
// - Fault status: update only, send on change, on request, or both.
// - Emergency uses fallback value and drives heating valve by PWM.
// - Single-value two-pipe: combined value drives heating valve and fan.
// - Bus recovery sets heating/cooling: keep previous, heating or cooling.
// - Single-value four-pipe: toggle picks mode and closes the idle valve.
// - Toggle value equal to heating polarity selects heating, else cooling.
module fcl_top #(
  parameter int CYC_PER_TICK = fcl_pkg::CYC_PER_TICK
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic ctl_stb_i,
  input wire logic [6:0] ctl_val_i,
  input wire logic cool_stb_i,
  input wire logic [6:0] cool_val_i,
  input wire logic [3:0] lim_stb_i,
  input wire logic [3:0] lim_val_i,
  input wire logic tog_stb_i,
  input wire logic tog_val_i,
  input wire logic manual_i,
  input wire logic [1:0] manual_spd_i,
  input wire logic bus_recov_i,
  output logic [1:0] fan_spd_o,
  output logic [6:0] heat_valve_o,
  output logic [6:0] cool_valve_o,
  output logic heat_pwm_o,
  output logic heating_o,
  output logic fault_o,
  output logic fault_send_o
);

  localparam int TW = $clog2(CYC_PER_TICK);

  // ==========================================================
  // Register bus
  logic [31:0] ctrl_r, thresh_r, mon_r, lim_cfg_r, pwm_r, stat_w, rd_mux, hrdata_r;
  logic wr_en_r, send_req_r, auto_r;
  logic [7:0] wr_ofs_r;
  logic addr_ok;
  logic [1:0] fan_spd_r;
  logic [6:0] heat_valve_r, cool_valve_r;
  logic fault_r, heating_r;
  logic [3:0] lim_act_r;

  assign addr_ok = hsel_i && hready_i && htrans_i[1];
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_r;

  assign stat_w = {1'b0, cool_valve_r, 1'b0, heat_valve_r, 7'h00, lim_act_r, auto_r,
                   heating_r, fault_r, fan_spd_r};

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr_i[7:0])
      fcl_pkg::OFS_CTRL: begin
        rd_mux = ctrl_r;
        rd_mux[fcl_pkg::F_AUTO] = auto_r;
      end
      fcl_pkg::OFS_THRESH: rd_mux = thresh_r;
      fcl_pkg::OFS_MON: rd_mux = mon_r;
      fcl_pkg::OFS_LIM: rd_mux = lim_cfg_r;
      fcl_pkg::OFS_PWM: rd_mux = pwm_r;
      fcl_pkg::OFS_STAT: rd_mux = stat_w;
      default: rd_mux = 32'h0000_0000;
    endcase
    if (haddr_i[31:8] != 24'h00_0000) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_en_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_en_r <= addr_ok && hwrite_i && (haddr_i[31:8] == 24'h00_0000);
      wr_ofs_r <= haddr_i[7:0];
      if (addr_ok && !hwrite_i) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= fcl_pkg::CTRL_RST;
      thresh_r <= fcl_pkg::THRESH_RST;
      mon_r <= fcl_pkg::MON_RST;
      lim_cfg_r <= fcl_pkg::LIM_RST;
      pwm_r <= fcl_pkg::PWM_RST;
      send_req_r <= 1'b0;
    end else begin
      send_req_r <= 1'b0;
      if (wr_en_r) begin
        unique case (wr_ofs_r)
          fcl_pkg::OFS_CTRL: ctrl_r <= hwdata_i;
          fcl_pkg::OFS_THRESH: thresh_r <= hwdata_i;
          fcl_pkg::OFS_MON: mon_r <= hwdata_i;
          fcl_pkg::OFS_LIM: lim_cfg_r <= hwdata_i;
          fcl_pkg::OFS_PWM: pwm_r <= hwdata_i;
          fcl_pkg::OFS_REQ: send_req_r <= hwdata_i[fcl_pkg::F_REQ_SEND];
          default: send_req_r <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // Configuration fields
  logic lim_en, mon_en, heat_pol;
  logic [2:0] hv_mode;
  logic [1:0] recov_mode, send_mode, start_spd;
  logic [6:0] fallback;
  logic [4:0] hyst;
  logic [15:0] mon_time, pcyc;
  logic [7:0] dwell_s;

  assign lim_en = ctrl_r[fcl_pkg::F_LIMEN];
  assign mon_en = ctrl_r[fcl_pkg::F_MONEN];
  assign heat_pol = ctrl_r[fcl_pkg::F_HPOL];
  assign hv_mode = ctrl_r[fcl_pkg::F_MODE +: 3];
  assign recov_mode = ctrl_r[fcl_pkg::F_RECOV +: 2];
  assign send_mode = ctrl_r[fcl_pkg::F_SEND +: 2];
  assign hyst = thresh_r[fcl_pkg::F_HYST +: 5];
  assign mon_time = (mon_r[fcl_pkg::F_MONT +: 16] < fcl_pkg::MON_MIN_S) ?
                    fcl_pkg::MON_MIN_S : mon_r[fcl_pkg::F_MONT +: 16];
  assign fallback = mon_r[fcl_pkg::F_FALLB +: 7];
  assign pcyc = pwm_r[fcl_pkg::F_PCYC +: 16];
  assign start_spd = pwm_r[fcl_pkg::F_SSPD +: 2];
  assign dwell_s = pwm_r[fcl_pkg::F_SDWELL +: 8];

  // ==========================================================
  // Time base: 10 ms tick and one-second tick
  logic [TW-1:0] div_r;
  logic [6:0] sub_r;
  logic tick_r, sec_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_r <= '0;
      sub_r <= 7'h00;
      tick_r <= 1'b0;
      sec_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      sec_r <= 1'b0;
      if (div_r == TW'(CYC_PER_TICK - 1)) begin
        div_r <= '0;
        tick_r <= 1'b1;
      end else begin
        div_r <= div_r + TW'(1);
      end
      if (tick_r) begin
        if (sub_r == fcl_pkg::TICKS_PER_S - 7'h01) begin
          sub_r <= 7'h00;
          sec_r <= 1'b1;
        end else begin
          sub_r <= sub_r + 7'h01;
        end
      end
    end
  end

  // ==========================================================
  // Control value reception and timeout monitoring
  logic [6:0] cv_r, xcool_r, cv_eff;
  logic [15:0] mon_cnt_r;
  logic fault_d_r, fault_send_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cv_r <= 7'h00;
      xcool_r <= 7'h00;
    end else begin
      if (ctl_stb_i) begin
        cv_r <= ctl_val_i;
      end
      if (cool_stb_i) begin
        xcool_r <= cool_val_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mon_cnt_r <= 16'h0000;
      fault_r <= 1'b0;
    end else if (ctl_stb_i || !mon_en) begin
      mon_cnt_r <= 16'h0000;
      fault_r <= 1'b0;
    end else if (sec_r && !fault_r) begin
      mon_cnt_r <= mon_cnt_r + 16'h0001;
      // Full span elapsed, never early
      if (mon_cnt_r >= mon_time) begin
        fault_r <= 1'b1;
      end
    end
  end

  assign cv_eff = fault_r ? fallback : cv_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fault_d_r <= 1'b0;
      fault_send_r <= 1'b0;
    end else begin
      fault_d_r <= fault_r;
      fault_send_r <= ((fault_r != fault_d_r) && send_mode[0]) ||
                      (send_req_r && send_mode[1]);
    end
  end

  // ==========================================================
  // Speed bands with hysteresis
  logic [7:0] thr [3];
  logic [7:0] up_pt [3];
  logic [7:0] dn_pt [3];
  logic [1:0] lvl_up, lvl_dn, auto_spd_r, man_spd_r, req_spd;

  assign thr[0] = {1'b0, thresh_r[fcl_pkg::F_THR1 +: 7]};
  assign thr[1] = {1'b0, thresh_r[fcl_pkg::F_THR2 +: 7]};
  assign thr[2] = {1'b0, thresh_r[fcl_pkg::F_THR3 +: 7]};

  always_comb begin
    lvl_up = 2'h0;
    lvl_dn = 2'h0;
    for (int i = 0; i < 3; i++) begin
      up_pt[i] = thr[i] + {3'h0, hyst};
      dn_pt[i] = (thr[i] > {3'h0, hyst}) ? thr[i] - {3'h0, hyst} : 8'h00;
      if ({1'b0, cv_eff} >= up_pt[i]) begin
        lvl_up = lvl_up + 2'h1;
      end
      if ({1'b0, cv_eff} >= dn_pt[i]) begin
        lvl_dn = lvl_dn + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      auto_spd_r <= 2'h0;
    end else if (lvl_up > auto_spd_r) begin
      auto_spd_r <= lvl_up;
    end else if (lvl_dn < auto_spd_r) begin
      auto_spd_r <= lvl_dn;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      auto_r <= 1'b0;
      man_spd_r <= 2'h0;
    end else if (manual_i) begin
      auto_r <= 1'b0;
      man_spd_r <= manual_spd_i;
    end else if (wr_en_r && wr_ofs_r == fcl_pkg::OFS_CTRL && hwdata_i[fcl_pkg::F_AUTO]) begin
      auto_r <= 1'b1;
    end
  end

  assign req_spd = auto_r ? auto_spd_r : man_spd_r;

  // ==========================================================
  // Limitations
  logic lim_any, lim_any_d_r;
  logic [1:0] win_idx, lim_spd, held_spd_r, lo_spd, hi_spd, target;
  fcl_pkg::fcl_lim_t win_mode;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lim_act_r <= 4'h0;
    end else if (!lim_en) begin
      lim_act_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (lim_stb_i[i]) begin
          lim_act_r[i] <= lim_val_i[i];
        end
      end
    end
  end

  always_comb begin
    lim_any = 1'b0;
    win_idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (lim_act_r[i] && lim_cfg_r[i * fcl_pkg::LIM_STRIDE + fcl_pkg::F_LMODE +: 2] !=
          fcl_pkg::LIM_INACT) begin
        lim_any = 1'b1;
        win_idx = 2'(i);
      end
    end
  end

  assign win_mode = fcl_pkg::fcl_lim_t'(
      lim_cfg_r[win_idx * fcl_pkg::LIM_STRIDE + fcl_pkg::F_LMODE +: 2]);
  assign lo_spd = lim_cfg_r[win_idx * fcl_pkg::LIM_STRIDE + fcl_pkg::F_LLO +: 2];
  assign hi_spd = lim_cfg_r[win_idx * fcl_pkg::LIM_STRIDE + fcl_pkg::F_LHI +: 2];

  always_comb begin
    lim_spd = req_spd;
    unique case (win_mode)
      fcl_pkg::LIM_INACT: lim_spd = req_spd;
      fcl_pkg::LIM_HOLD: lim_spd = lim_any_d_r ? held_spd_r : fan_spd_r;
      fcl_pkg::LIM_OFF: lim_spd = 2'h0;
      fcl_pkg::LIM_ON: begin
        if (req_spd < lo_spd) begin
          lim_spd = lo_spd;
        end else if (req_spd > hi_spd) begin
          lim_spd = hi_spd;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lim_any_d_r <= 1'b0;
      held_spd_r <= 2'h0;
    end else begin
      lim_any_d_r <= lim_any;
      if (lim_any && !lim_any_d_r) begin
        held_spd_r <= fan_spd_r;
      end
    end
  end

  assign target = lim_any ? lim_spd : req_spd;

  // ==========================================================
  // Fan start-up sequencing
  fcl_pkg::fcl_fan_t fan_st_r;
  logic [7:0] dwell_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fan_st_r <= fcl_pkg::FS_OFF;
      fan_spd_r <= 2'h0;
      dwell_r <= 8'h00;
    end else begin
      unique case (fan_st_r)
        fcl_pkg::FS_OFF: begin
          fan_spd_r <= 2'h0;
          if (target != 2'h0 && start_spd != 2'h0) begin
            fan_st_r <= fcl_pkg::FS_START;
            fan_spd_r <= start_spd;
            dwell_r <= dwell_s;
          end else if (target != 2'h0) begin
            fan_st_r <= fcl_pkg::FS_RUN;
            fan_spd_r <= target;
          end
        end
        fcl_pkg::FS_START: begin
          if (sec_r && dwell_r != 8'h00) begin
            dwell_r <= dwell_r - 8'h01;
          end else if (dwell_r == 8'h00) begin
            fan_st_r <= fcl_pkg::FS_RUN;
          end
        end
        fcl_pkg::FS_RUN: begin
          fan_spd_r <= target;
          if (target == 2'h0) begin
            fan_st_r <= fcl_pkg::FS_OFF;
          end
        end
        default: fan_st_r <= fcl_pkg::FS_OFF;
      endcase
    end
  end

  // ==========================================================
  // Heating/cooling selection and valves
  logic [6:0] hv_nxt, cv_nxt;
  logic [23:0] phase_r, per_ticks, on_ticks;
  logic pwm_r_on;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      heating_r <= 1'b1;
    end else if (bus_recov_i && recov_mode == fcl_pkg::RCV_HEAT) begin
      heating_r <= 1'b1;
    end else if (bus_recov_i && recov_mode == fcl_pkg::RCV_COOL) begin
      heating_r <= 1'b0;
    end else if (tog_stb_i) begin
      heating_r <= (tog_val_i == heat_pol);
    end
  end

  always_comb begin
    hv_nxt = 7'h00;
    cv_nxt = 7'h00;
    unique case (fcl_pkg::fcl_hvac_t'(hv_mode))
      fcl_pkg::HV_1CV_2P: begin
        hv_nxt = cv_eff;
        cv_nxt = xcool_r;
      end
      fcl_pkg::HV_1CV_4P_SW: begin
        hv_nxt = heating_r ? cv_eff : 7'h00;
        cv_nxt = heating_r ? 7'h00 : cv_eff;
      end
      default: hv_nxt = cv_eff;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      heat_valve_r <= 7'h00;
      cool_valve_r <= 7'h00;
    end else if (!lim_any) begin
      heat_valve_r <= hv_nxt;
      cool_valve_r <= cv_nxt;
    end
  end

  assign per_ticks = 24'(pcyc * fcl_pkg::TICKS_PER_S);
  assign on_ticks = 24'(pcyc * fallback);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      phase_r <= 24'h00_0000;
      pwm_r_on <= 1'b0;
    end else begin
      if (tick_r) begin
        phase_r <= (phase_r + 24'h00_0001 >= per_ticks) ? 24'h00_0000 : phase_r + 24'h00_0001;
      end
      pwm_r_on <= fault_r && (phase_r < on_ticks);
    end
  end

  assign fan_spd_o = fan_spd_r;
  assign heat_valve_o = heat_valve_r;
  assign cool_valve_o = cool_valve_r;
  assign heat_pwm_o = pwm_r_on;
  assign heating_o = heating_r;
  assign fault_o = fault_r;
  assign fault_send_o = fault_send_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_lim0_on;
    lim_en && lim_stb_i[0] && lim_val_i[0];
  endsequence
  sequence s_lim0_wins;
    lim_act_r[0] && lim_cfg_r[fcl_pkg::F_LMODE +: 2] != fcl_pkg::LIM_INACT;
  endsequence

  chk_speed_rise: assert property (auto_spd_r == 2'h0 && {1'b0, cv_eff} >= up_pt[0]
    |=> auto_spd_r != 2'h0) else $error("fan did not leave off");
  chk_band_keep: assert property (lvl_up <= auto_spd_r && lvl_dn >= auto_spd_r
    |=> $stable(auto_spd_r)) else $error("speed moved inside band");
  chk_lim_set: assert property (s_lim0_on |=> lim_act_r[0])
    else $error("limitation not activated");
  chk_lim_prio: assert property (s_lim0_wins |-> win_idx == 2'h0)
    else $error("limitation priority wrong");
  chk_valve_hold: assert property (lim_any && $past(lim_any) |-> $stable(heat_valve_r))
    else $error("valve changed during limitation");
  chk_fault_value: assert property (fault_r |-> cv_eff == fallback)
    else $error("fallback not used");
  chk_manual_exit: assert property (manual_i && lim_stb_i == 4'h0 && lim_en
    |=> !auto_r && lim_act_r == $past(lim_act_r)) else $error("manual exit wrong");
  chk_idle_close: assert property ((hv_mode == fcl_pkg::HV_1CV_4P_SW && heating_r &&
    !lim_any) [*2] |-> cool_valve_r == 7'h00) else $error("idle valve open");
  chk_start_speed: assert property (fan_st_r == fcl_pkg::FS_OFF && target != 2'h0 &&
    start_spd != 2'h0 |=> fan_spd_r == $past(start_spd)) else $error("no start-up");
  chk_send_change: assert property ($changed(fault_r) && send_mode[0]
    |=> fault_send_o) else $error("fault change not sent");

endmodule // fcl_top

// ### tb/fcl_thermo_model.sv
`timescale 1ns/1ps
// ==========================================================
// Thermostat sending control value telegrams
module fcl_thermo_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [6:0] val_i,
  output logic stb_o,
  output logic [6:0] val_o
);
  initial begin
    stb_o = 1'b0;
    val_o = 7'h00;
  end
  // Sends when told; t_mon stops sending long enough for the monitor time to expire
  always @(posedge clk_i) begin
    stb_o <= go_i;
    val_o <= go_i ? val_i : ~val_o;
  end
endmodule // fcl_thermo_model

// ### tb/fcl_top_test.sv
`timescale 1ns/1ps
module fcl_top_test;
  logic clk_i, sys_rst_i, hsel, hwrite, hready, hresp, go;
  logic [1:0] htrans, mspd, fan;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic ctl_stb, cool_stb, tog_stb, tog_val, manual, recov;
  logic [6:0] ctl_val, cool_val, gval, hv, cv;
  logic [3:0] lim_stb, lim_val;
  logic pwm, heating, fault, fsend;
  int err_count, check_count, send_cnt;

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  fcl_thermo_model u_thermo (.clk_i(clk_i), .go_i(go), .val_i(gval), .stb_o(ctl_stb),
    .val_o(ctl_val));

  fcl_top #(.CYC_PER_TICK(10)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .ctl_stb_i(ctl_stb), .ctl_val_i(ctl_val), .cool_stb_i(cool_stb),
    .cool_val_i(cool_val), .lim_stb_i(lim_stb), .lim_val_i(lim_val), .tog_stb_i(tog_stb),
    .tog_val_i(tog_val), .manual_i(manual), .manual_spd_i(mspd), .bus_recov_i(recov),
    .fan_spd_o(fan), .heat_valve_o(hv), .cool_valve_o(cv), .heat_pwm_o(pwm),
    .heating_o(heating), .fault_o(fault), .fault_send_o(fsend));

  always @(posedge clk_i) if (fsend === 1'b1) send_cnt++;

  // ==========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic tg(input logic [6:0] v);
    @(posedge clk_i);
    go <= 1'b1;
    gval <= v;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic lim(input logic [3:0] s, input logic [3:0] v);
    @(posedge clk_i);
    lim_stb <= s;
    lim_val <= v;
    @(posedge clk_i);
    lim_stb <= 4'h0;
    repeat (4) @(posedge clk_i);
  endtask

  // Event pulse: 0 toggle, 1 manual, 2 recovery, 3 extra cooling value
  task automatic ev(input int k, input logic [6:0] v);
    @(posedge clk_i);
    case (k)
      0: begin
        tog_stb <= 1'b1;
        tog_val <= v[0];
      end
      1: begin
        manual <= 1'b1;
        mspd <= v[1:0];
      end
      2: recov <= 1'b1;
      default: begin
        cool_stb <= 1'b1;
        cool_val <= v;
      end
    endcase
    @(posedge clk_i);
    {tog_stb, manual, recov, cool_stb} <= 4'h0;
    repeat (4) @(posedge clk_i);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] a[6];
    logic [31:0] e[6];
    a = '{fcl_pkg::OFS_CTRL, fcl_pkg::OFS_THRESH, fcl_pkg::OFS_MON, fcl_pkg::OFS_LIM,
      fcl_pkg::OFS_PWM, 8'h1C};
    e = '{fcl_pkg::CTRL_RST, fcl_pkg::THRESH_RST, fcl_pkg::MON_RST, fcl_pkg::LIM_RST,
      fcl_pkg::PWM_RST, 32'h0000_0000};
    for (int i = 0; i < 6; i++) begin
      ahb(1'b0, a[i], 32'h0);
      chk("reg", rd, e[i]);
    end
  endtask

  task automatic t_band();
    ahb(1'b1, fcl_pkg::OFS_PWM, 32'h0000_000A);
    ahb(1'b1, fcl_pkg::OFS_CTRL, 32'h0000_0301);
    tg(7'd50);
    chk("fan", fan, 32'h2);
    chk("heat valve", hv, 32'd50);
    tg(7'd38);
    chk("fan", fan, 32'h2);
    tg(7'd34);
    chk("fan", fan, 32'h1);
    tg(7'd4);
    chk("fan", fan, 32'h0);
    ev(3, 7'd25);
    chk("cool valve", cv, 32'd25);
    ahb(1'b1, fcl_pkg::OFS_THRESH, 32'h0046_280A);
    tg(7'd10);
    chk("fan", fan, 32'h1);
    tg(7'd9);
    chk("fan", fan, 32'h0);
    tg(7'd70);
    chk("fan", fan, 32'h3);
  endtask

  task automatic t_lim();
    ahb(1'b1, fcl_pkg::OFS_CTRL, 32'h0000_0303);
    ahb(1'b1, fcl_pkg::OFS_LIM, 32'h0000_0217);
    tg(7'd90);
    lim(4'h3, 4'h3);
    chk("fan", fan, 32'h1);
    ev(1, 7'd2);
    ahb(1'b0, fcl_pkg::OFS_STAT, 32'h0);
    chk("status", rd[8:4], 32'h06);
    chk("fan", fan, 32'h1);
    tg(7'd20);
    chk("heat valve", hv, 32'd90);
    lim(4'h1, 4'h0);
    chk("fan", fan, 32'h0);
    lim(4'h2, 4'h0);
    chk("heat valve", hv, 32'd20);
    chk("fan", fan, 32'h2);
  endtask

  task automatic t_mon();
    int pwm_cnt;
    ahb(1'b1, fcl_pkg::OFS_CTRL, 32'h0000_0305);
    ahb(1'b1, fcl_pkg::OFS_MON, 32'h001E_001E);
    send_cnt = 0;
    tg(7'd0);
    repeat (29000) @(posedge clk_i);
    chk("fault", fault, 32'h0);
    repeat (2000) @(posedge clk_i);
    chk("fault", fault, 32'h1);
    chk("fan", fan, 32'h1);
    chk("heat valve", hv, 32'd30);
    pwm_cnt = 0;
    repeat (10000) begin
      @(posedge clk_i);
      pwm_cnt += pwm;
    end
    chk("pwm on", pwm_cnt, 32'd3000);
    tg(7'd0);
    chk("fault", fault, 32'h0);
    chk("sends", send_cnt, 32'd2);
    ahb(1'b1, fcl_pkg::OFS_CTRL, 32'h0000_0705);
    ahb(1'b1, fcl_pkg::OFS_REQ, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk("sends", send_cnt, 32'd3);
  endtask

  task automatic t_tog();
    ahb(1'b1, fcl_pkg::OFS_PWM, 32'h0007_000A);
    ahb(1'b1, fcl_pkg::OFS_CTRL, 32'h0000_0349);
    tg(7'd60);
    chk("fan", fan, 32'h3);
    repeat (1100) @(posedge clk_i);
    chk("fan", fan, 32'h2);
    ev(0, 7'd0);
    chk("heating", heating, 32'h0);
    chk("heat valve", hv, 32'd0);
    chk("cool valve", cv, 32'd60);
    ev(0, 7'd1);
    chk("heating", heating, 32'h1);
    ev(0, 7'd0);
    ev(2, 7'd0);
    chk("heating", heating, 32'h1);
    ahb(1'b1, fcl_pkg::OFS_CTRL, 32'h0000_0389);
    ev(2, 7'd0);
    chk("heating", heating, 32'h0);
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    report_and_stop();
  end

  initial begin
    {sys_rst_i, hsel, go, manual, recov} = 5'h18;
    {hwrite, ctl_stb, cool_stb, tog_stb, tog_val} = 5'h0;
    {htrans, mspd, lim_stb, lim_val} = 12'h0;
    {haddr, hwdata} = 64'h0;
    {gval, cool_val} = 14'h0;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_band();
    t_lim();
    t_mon();
    t_tog();
    report_and_stop();
  end
endmodule // fcl_top_test
